//--- common/ieb_consts.vh
`ifndef IEB_CONSTS_VH
`define IEB_CONSTS_VH

// ****************************************************************
// Register byte offsets on the Avalon-MM slave.
// ****************************************************************
`define IEB_OFS_ENABLE 5'h00
`define IEB_OFS_FLAGS 5'h04
`define IEB_OFS_FLAG_SET 5'h08
`define IEB_OFS_SOURCE 5'h0C
`define IEB_OFS_ACTIVE 5'h10
`define IEB_OFS_IRQ 5'h14

// ****************************************************************
// Field positions of the enable, flag and request vectors.
// ****************************************************************
`define IEB_BIT_RSVD15 15
`define IEB_BIT_DMA_CH1 14
`define IEB_BIT_ADC_FIRST 13
`define IEB_BIT_SER1_TX 12
`define IEB_BIT_SER1_RX 11
`define IEB_BIT_SYNC1_EVENT 10
`define IEB_BIT_SYNC1_ERROR 9
`define IEB_BIT_TIMER_THREE 8
`define IEB_BIT_TIMER_TWO 7
`define IEB_BIT_OUT_CMP2 6
`define IEB_BIT_IN_CAP2 5
`define IEB_BIT_DMA_CH0 4
`define IEB_BIT_TIMER_ONE 3
`define IEB_BIT_OUT_CMP1 2
`define IEB_BIT_IN_CAP1 1
`define IEB_BIT_EXT_PIN0 0

// ****************************************************************
// Widths, reset values and masks.
// ****************************************************************
`define IEB_NUM_SRC 15
`define IEB_REG_W 16
`define IEB_RST_ENABLE 16'h0000
`define IEB_RST_FLAGS 15'h0000
`define IEB_IMPL_MASK 16'h7FFF
`define IEB_RST_RDATA 32'h0000_0000

`endif

//--- design/ieb_flag_cell.v
`timescale 1ns/1ps

// ****************************************************************
// One sticky pending flag.
// ****************************************************************
module ieb_flag_cell (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Set and clear strobes
  input wire set_i,
  input wire clr_i,
  // Flag state
  output reg flag_o
);

  // A set in the same cycle as a clear wins, so no event is lost.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_o <= 1'b0;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (clr_i) begin
      flag_o <= 1'b0;
    end
  end

endmodule // ieb_flag_cell

//--- design/ieb_enable_bank.v
`timescale 1ns/1ps
`include "ieb_consts.vh"

module ieb_enable_bank #(
  parameter ADDR_W = 5
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Avalon-MM slave
  input wire [ADDR_W-1:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  // Request sources
  input wire [`IEB_NUM_SRC-1:0] src_evt_i,
  // Toward the processor interrupt logic
  output reg [`IEB_NUM_SRC-1:0] fwd_req_o,
  output reg irq_o
);

  // ****************************************************************
  // Helper functions.
  // ****************************************************************

  // Compares the word part of a byte address with a register offset.
  function ieb_sel;
    input [ADDR_W-1:0] addr;
    input [4:0] ofs;
    begin
      ieb_sel = (addr[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
    end
  endfunction

  // Expands the two low byte enables into a 16-bit write mask.
  // Lanes 3 and 2 carry no register bits, so their enables are ignored.
  function [`IEB_REG_W-1:0] ieb_lane_mask;
    input [3:0] be;
    begin
      ieb_lane_mask = {{8{be[1]}}, {8{be[0]}}};
    end
  endfunction

  // Places a source vector in the low part of a bus word; the upper
  // bits always read zero.
  function [31:0] ieb_word;
    input [`IEB_NUM_SRC-1:0] vec;
    begin
      ieb_word = {{(32-`IEB_NUM_SRC){1'b0}}, vec};
    end
  endfunction

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  reg [`IEB_REG_W-1:0] enable;
  reg [`IEB_REG_W-1:0] next_enable;
  reg [31:0] next_rdata;
  wire [`IEB_NUM_SRC-1:0] flags;
  wire [`IEB_NUM_SRC-1:0] en_vec;
  wire [`IEB_NUM_SRC-1:0] active;
  wire [`IEB_NUM_SRC-1:0] sw_set;
  wire [`IEB_NUM_SRC-1:0] sw_clr;
  wire [`IEB_REG_W-1:0] wmask;
  wire [`IEB_REG_W-1:0] wdata16;
  wire bus_req;
  wire rd_take;
  wire wr_done;
  wire sel_enable;
  wire sel_flags;
  wire sel_flag_set;
  wire sel_source;
  wire sel_active;
  wire sel_irq;
  wire wr_enable;
  wire wr_flag_clr;
  wire wr_flag_set;
  wire [31:0] word_enable;
  wire [31:0] word_flags;
  wire [31:0] word_source;
  wire [31:0] word_active;
  wire [31:0] word_irq;
  // Enable bits named as software sees them.
  wire dma_ch1_done_irq_en;
  wire adc_first_irq_en;
  wire serial_port1_tx_irq_en;
  wire serial_port1_rx_irq_en;
  wire sync_port1_event_irq_en;
  wire sync_port1_error_irq_en;
  wire timer_three_irq_en;
  wire timer_two_irq_en;
  wire out_compare2_irq_en;
  wire in_capture2_irq_en;
  wire dma_ch0_done_irq_en;
  wire timer_one_irq_en;
  wire out_compare1_irq_en;
  wire in_capture1_irq_en;
  wire ext_pin0_irq_en;

  // ****************************************************************
  // Bus handshake.
  // ****************************************************************

  // Every transfer takes one wait state. The read word is captured
  // while waitrequest is high, so it stands at the completing edge.
  // A write dropped before it completes only ends the wait state; a dropped read has already loaded the read word.
  assign bus_req = avs_read_i | avs_write_i;
  assign rd_take = avs_read_i & avs_waitrequest_o;
  assign wr_done = avs_write_i & ~avs_waitrequest_o;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if (bus_req && avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b0;
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  // ****************************************************************
  // Address decode.
  // ****************************************************************
  assign sel_enable = ieb_sel(avs_address_i, `IEB_OFS_ENABLE);
  assign sel_flags = ieb_sel(avs_address_i, `IEB_OFS_FLAGS);
  assign sel_flag_set = ieb_sel(avs_address_i, `IEB_OFS_FLAG_SET);
  assign sel_source = ieb_sel(avs_address_i, `IEB_OFS_SOURCE);
  assign sel_active = ieb_sel(avs_address_i, `IEB_OFS_ACTIVE);
  assign sel_irq = ieb_sel(avs_address_i, `IEB_OFS_IRQ);

  assign wmask = ieb_lane_mask(avs_byteenable_i);
  assign wdata16 = avs_writedata_i[`IEB_REG_W-1:0] & wmask;

  // ****************************************************************
  // Write strobes.
  // ****************************************************************

  // A write acts only at its completing edge, so a waiting request never
  // touches the state. Writes to the read-only words are dropped silently.
  assign wr_enable = wr_done & sel_enable;
  assign wr_flag_clr = wr_done & sel_flags;
  assign wr_flag_set = wr_done & sel_flag_set;

  // ****************************************************************
  // Enable register.
  // ****************************************************************
  // Lanes not enabled keep their old value, so a one-byte write leaves
  // the other byte untouched. Bit 15 is masked and always stays zero.
  always @* begin
    next_enable = enable;
    if (wr_enable) begin
      next_enable = ((enable & ~wmask) | wdata16) & `IEB_IMPL_MASK;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enable <= `IEB_RST_ENABLE;
    end else begin
      enable <= next_enable;
    end
  end

  // ****************************************************************
  // Named enable fields.
  // ****************************************************************
  assign dma_ch1_done_irq_en = enable[`IEB_BIT_DMA_CH1];
  assign adc_first_irq_en = enable[`IEB_BIT_ADC_FIRST];
  assign serial_port1_tx_irq_en = enable[`IEB_BIT_SER1_TX];
  assign serial_port1_rx_irq_en = enable[`IEB_BIT_SER1_RX];
  assign sync_port1_event_irq_en = enable[`IEB_BIT_SYNC1_EVENT];
  assign sync_port1_error_irq_en = enable[`IEB_BIT_SYNC1_ERROR];
  assign timer_three_irq_en = enable[`IEB_BIT_TIMER_THREE];
  assign timer_two_irq_en = enable[`IEB_BIT_TIMER_TWO];
  assign out_compare2_irq_en = enable[`IEB_BIT_OUT_CMP2];
  assign in_capture2_irq_en = enable[`IEB_BIT_IN_CAP2];
  assign dma_ch0_done_irq_en = enable[`IEB_BIT_DMA_CH0];
  assign timer_one_irq_en = enable[`IEB_BIT_TIMER_ONE];
  assign out_compare1_irq_en = enable[`IEB_BIT_OUT_CMP1];
  assign in_capture1_irq_en = enable[`IEB_BIT_IN_CAP1];
  assign ext_pin0_irq_en = enable[`IEB_BIT_EXT_PIN0];

  // ****************************************************************
  // Per-source gating.
  // ****************************************************************

  // Each source sees only its own enable bit: a plain AND per source, with
  // nothing shared, so one enable can never open another source's path.
  assign en_vec[`IEB_BIT_DMA_CH1] = dma_ch1_done_irq_en;
  assign en_vec[`IEB_BIT_ADC_FIRST] = adc_first_irq_en;
  assign en_vec[`IEB_BIT_SER1_TX] = serial_port1_tx_irq_en;
  assign en_vec[`IEB_BIT_SER1_RX] = serial_port1_rx_irq_en;
  assign en_vec[`IEB_BIT_SYNC1_EVENT] = sync_port1_event_irq_en;
  assign en_vec[`IEB_BIT_SYNC1_ERROR] = sync_port1_error_irq_en;
  assign en_vec[`IEB_BIT_TIMER_THREE] = timer_three_irq_en;
  assign en_vec[`IEB_BIT_TIMER_TWO] = timer_two_irq_en;
  assign en_vec[`IEB_BIT_OUT_CMP2] = out_compare2_irq_en;
  assign en_vec[`IEB_BIT_IN_CAP2] = in_capture2_irq_en;
  assign en_vec[`IEB_BIT_DMA_CH0] = dma_ch0_done_irq_en;
  assign en_vec[`IEB_BIT_TIMER_ONE] = timer_one_irq_en;
  assign en_vec[`IEB_BIT_OUT_CMP1] = out_compare1_irq_en;
  assign en_vec[`IEB_BIT_IN_CAP1] = in_capture1_irq_en;
  assign en_vec[`IEB_BIT_EXT_PIN0] = ext_pin0_irq_en;

  // ****************************************************************
  // Pending flags.
  // ****************************************************************

  // Software may clear a flag by writing one, or raise it by writing
  // one to the set register for testing handlers.
  assign sw_clr = wr_flag_clr ? wdata16[`IEB_NUM_SRC-1:0] : `IEB_RST_FLAGS;
  assign sw_set = wr_flag_set ? wdata16[`IEB_NUM_SRC-1:0] : `IEB_RST_FLAGS;

  // The enable never touches the flags, so disabling a source keeps
  // its event pending until software clears it.
  genvar gi;
  generate
    for (gi = 0; gi < `IEB_NUM_SRC; gi = gi + 1) begin : g_flag
      ieb_flag_cell u_flag (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .set_i(src_evt_i[gi] | sw_set[gi]),
        .clr_i(sw_clr[gi]),
        .flag_o(flags[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Request forwarding and interrupt.
  // ****************************************************************
  assign active = flags & en_vec;

  // Registered outputs add one cycle of latency from flag or enable.
  // The summary interrupt is the OR of the gated requests, so it is never
  // more stale than they are.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fwd_req_o <= `IEB_RST_FLAGS;
      irq_o <= 1'b0;
    end else begin
      fwd_req_o <= active;
      irq_o <= |active;
    end
  end

  // ****************************************************************
  // Read words.
  // ****************************************************************
  assign word_enable = {16'h0000, enable & `IEB_IMPL_MASK};
  assign word_flags = ieb_word(flags);
  assign word_source = ieb_word(src_evt_i);
  assign word_active = ieb_word(active);
  assign word_irq = {31'h0000_0000, irq_o};

  // ****************************************************************
  // Read data.
  // ****************************************************************

  // Unmapped offsets fall through to zero. Capturing during the wait
  // state keeps the read path one flop deep; the price is a wait state
  // on every transfer.
  always @* begin
    next_rdata = `IEB_RST_RDATA;
    if (sel_enable) begin
      next_rdata = word_enable;
    end else if (sel_flags) begin
      next_rdata = word_flags;
    end else if (sel_source) begin
      next_rdata = word_source;
    end else if (sel_active) begin
      next_rdata = word_active;
    end else if (sel_irq) begin
      next_rdata = word_irq;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= `IEB_RST_RDATA;
    end else if (rd_take) begin
      avs_readdata_o <= next_rdata;
    end
  end

endmodule // ieb_enable_bank

//--- bench/ieb_src_model.sv
`timescale 1ns/1ps
// ****
// Request sources: each fire bit is registered and appears as an event one cycle later.
// ****
module ieb_src_model (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Commands and events
  input wire [14:0] fire_i,
  output reg [14:0] src_evt_o
);
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_evt_o <= 15'h0000;
    end else begin
      src_evt_o <= fire_i;
    end
  end
endmodule // ieb_src_model

//--- bench/ieb_enable_bank_sva.sv
`timescale 1ns/1ps
// ****
// Port checker.
// ****
module ieb_bank_sva (
  input wire clk_i,
  input wire rst_n_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  input wire [14:0] src_evt_i,
  input wire [14:0] fwd_req_o,
  input wire irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_req; (avs_read_i || avs_write_i) && avs_waitrequest_o; endsequence
  sequence s_ack; !avs_waitrequest_o ##1 avs_waitrequest_o; endsequence
  property p_hs; s_req |=> s_ack; endproperty
  a_hs: assert property (p_hs) else $error("Ack missing.");
  property p_ack; !avs_waitrequest_o |-> $past(avs_read_i || avs_write_i); endproperty
  a_ack: assert property (p_ack) else $error("Ack without request.");
  property p_irq; irq_o == |fwd_req_o; endproperty
  a_irq: assert property (p_irq) else $error("Irq differs from requests.");
  property p_rise;
    |(fwd_req_o & ~$past(fwd_req_o) & ~$past(src_evt_i, 2)) |-> $past(avs_write_i, 2);
  endproperty
  a_rise: assert property (p_rise) else $error("Request without cause.");
  property p_fall; |($past(fwd_req_o) & ~fwd_req_o) |-> $past(avs_write_i, 2); endproperty
  a_fall: assert property (p_fall) else $error("Request lost alone.");
  property p_rdhi; avs_readdata_o[31:15] == 17'h00000; endproperty
  a_rdhi: assert property (p_rdhi) else $error("High read bits set.");
  property p_rdst; $changed(avs_readdata_o) |-> $past(avs_read_i); endproperty
  a_rdst: assert property (p_rdst) else $error("Read data moved.");
  property p_irqr; $rose(irq_o) |-> $past(avs_write_i, 2) || (|$past(src_evt_i, 2)); endproperty
  a_irqr: assert property (p_irqr) else $error("Irq without cause.");
endmodule // ieb_bank_sva

bind ieb_enable_bank ieb_bank_sva ieb_bank_sva_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .src_evt_i(src_evt_i), .fwd_req_o(fwd_req_o),
  .irq_o(irq_o));

//--- bench/test_interrupt_enable_bank_zero.sv
`timescale 1ns/1ps
`include "ieb_consts.vh"
module test_interrupt_enable_bank_zero;
  reg clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg [4:0] adr = 5'h00;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg [31:0] wd = 32'h0;
  reg [3:0] be = 4'h0;
  reg [14:0] fire = 15'h0;
  wire [31:0] rdat;
  wire wreq;
  wire [14:0] src;
  wire [14:0] fwd;
  wire irq;
  logic [31:0] q[$];
  logic [31:0] seed = 32'd37772;
  int errors = 0;
  int tests_run = 0;
  int i;
  always #5 clk_i = ~clk_i;
  ieb_enable_bank ieb_enable_bank_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .src_evt_i(src), .fwd_req_o(fwd), .irq_o(irq));
  ieb_src_model ieb_src_model_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .fire_i(fire),
    .src_evt_o(src));
  // ****
  // Shared tasks.
  // ****
  function logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // The request is held until waitrequest is sampled low at a rising edge,
  // and is dropped right after that same edge.
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk_i);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    be <= b;
    do begin
      @(posedge clk_i);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) errors++;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task rdx(input logic [4:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(1'b0, a, 32'h0, 4'hF);
  endtask
  task fire_all(input logic [14:0] m);
    @(posedge clk_i);
    fire <= m;
    @(posedge clk_i);
    fire <= 15'h0;
    repeat (3) @(negedge clk_i);
  endtask
  task tally_and_finish;
    $display("Counts: %0d compared, %0d errors", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    if (rd === 1'b1 && wreq === 1'b0) chk(rdat, q.pop_front());
  end
  // Generous bound: the whole run needs only a few hundred cycles.
  initial begin
    #200000;
    errors++;
    tally_and_finish;
  end
  // ****
  // Scenarios.
  // ****
  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rdx(`IEB_OFS_ENABLE, 32'h0);
    rdx(`IEB_OFS_FLAGS, 32'h0);
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      bus(1'b1, `IEB_OFS_ENABLE, seed, 4'hF);
      rdx(`IEB_OFS_ENABLE, seed & 32'h7FFF);
    end
    bus(1'b1, `IEB_OFS_ENABLE, 32'h0, 4'hF);
    bus(1'b1, `IEB_OFS_ENABLE, 32'hFFFF, 4'h1);
    rdx(`IEB_OFS_ENABLE, 32'h00FF);
    bus(1'b1, 5'h18, 32'hFFFF, 4'hF);
    rdx(5'h18, 32'h0);
    $display("Test register access done");
    for (i = 0; i < 15; i++) begin
      bus(1'b1, `IEB_OFS_ENABLE, 32'h0, 4'hF);
      fire_all(15'h7FFF);
      chk(fwd, 32'h0);
      bus(1'b1, `IEB_OFS_ENABLE, 32'h1 << i, 4'hF);
      repeat (2) @(negedge clk_i);
      chk(fwd, 32'h1 << i);
      chk(irq, 32'h1);
      bus(1'b1, `IEB_OFS_ENABLE, 32'h0, 4'hF);
      repeat (2) @(negedge clk_i);
      chk(fwd, 32'h0);
      rdx(`IEB_OFS_FLAGS, 32'h7FFF);
      bus(1'b1, `IEB_OFS_FLAGS, 32'h7FFF, 4'hF);
    end
    $display("Test per-source gating done");
    bus(1'b1, `IEB_OFS_ENABLE, 32'h7FFF, 4'hF);
    fire_all(15'h0600);
    chk(fwd, 32'h0600);
    bus(1'b1, `IEB_OFS_FLAGS, 32'h0200, 4'hF);
    repeat (2) @(negedge clk_i);
    chk(fwd, 32'h0400);
    $display("Test event and error independence done");
    fork
      bus(1'b1, `IEB_OFS_FLAGS, 32'h1, 4'hF);
      fire_all(15'h0001);
    join
    chk(fwd, 32'h0401);
    rdx(`IEB_OFS_FLAGS, 32'h0401);
    $display("Test set against same-cycle clear done");
    bus(1'b1, `IEB_OFS_FLAGS, 32'h7FFF, 4'hF);
    bus(1'b1, `IEB_OFS_ENABLE, 32'h00F0, 4'hF);
    seed = xs(seed);
    bus(1'b1, `IEB_OFS_FLAG_SET, seed, 4'hF);
    rdx(`IEB_OFS_FLAGS, seed & 32'h7FFF);
    rdx(`IEB_OFS_ACTIVE, seed & 32'h00F0);
    rdx(`IEB_OFS_SOURCE, 32'h0);
    rdx(`IEB_OFS_FLAG_SET, 32'h0);
    rdx(`IEB_OFS_IRQ, ((seed & 32'h00F0) != 32'h0) ? 32'h1 : 32'h0);
    chk(irq, ((seed & 32'h00F0) != 32'h0) ? 32'h1 : 32'h0);
    $display("Test software set and read-only words done");
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    chk(fwd, 32'h0);
    chk(irq, 32'h0);
    rdx(`IEB_OFS_ENABLE, 32'h0);
    rdx(`IEB_OFS_FLAGS, 32'h0);
    $display("Test reset in mid-run done");
    tally_and_finish;
  end
endmodule // test_interrupt_enable_bank_zero
